//--- verilog/sbtg_pkg.sv
/*
  Shared constants for the sixteen-bit timer gate control block:
  register offsets, field positions, reset values and cycle counts.
  Assumes a single 25 MHz system clock and an 8-bit register port.
*/
package sbtg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CLOCK_CTRL = 2'h0;
  localparam logic [1:0] ADDR_GATE_CTRL  = 2'h1;

  // ----------------------------------------------------------------
  // Clock control fields
  // ----------------------------------------------------------------
  localparam int CC_SRC_LSB    = 6;
  localparam int CC_PS_LSB     = 4;
  localparam int CC_OSC_EN     = 3;
  localparam int CC_SYNC_DIS   = 2;
  localparam int CC_TIMER_ON   = 0;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Gate control fields
  // ----------------------------------------------------------------
  localparam int GC_GATE_EN    = 7;
  localparam int GC_POLARITY   = 6;
  localparam int GC_TOGGLE     = 5;
  localparam int GC_SPM        = 4;
  localparam int GC_GO_DONE    = 3;
  localparam int GC_VALUE      = 2;
  localparam int GC_SRC_LSB    = 0;
  localparam logic [7:0] GATE_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INSTR   = 2'h0;
  localparam logic [1:0] SRC_SYSTEM  = 2'h1;
  localparam logic [1:0] SRC_PIN_OSC = 2'h2;
  localparam logic [1:0] SRC_CAP_OSC = 2'h3;
  localparam logic [1:0] GSRC_PIN    = 2'h0;
  localparam logic [1:0] GSRC_T0_OVF = 2'h1;
  localparam logic [1:0] GSRC_CMP1   = 2'h2;
  localparam logic [1:0] GSRC_CMP2   = 2'h3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;  // Divide by four
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

endpackage

//--- verilog/sbtg_clk_if.sv
/*
  Interface between the timer control core and its clock selector.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface sbtg_clk_if;
  logic [1:0] srcSel;     // Clock source select
  logic [1:0] prescale;   // Prescale select
  logic       oscEn;      // Dedicated oscillator enable
  logic       syncDis;    // External clock sync disable
  logic       run;        // Timer on and gate open
  logic       clear;      // Restart prescaler
  logic [2:0] extLevels;  // Synced ext pin, osc pin, cap osc
  logic       tick;       // One count step

  modport core (output srcSel, prescale, oscEn, syncDis, run, clear,
                output extLevels, input tick);
  modport sel  (input srcSel, prescale, oscEn, syncDis, run, clear,
                input extLevels, output tick);
endinterface

//--- verilog/sbtg_sync.sv
/*
  Two flip-flop synchroniser for a group of asynchronous pins.
  Assumes each bit is independent; no bus coherence is implied.
*/
`timescale 1ns/1ps
module sbtg_sync #(
  parameter int W = 7
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbtg_sync_t;

  sbtg_sync_t st_ff;
  sbtg_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.s1 = asyncIn;
    nxt_st.s2 = st_ff.s1;
  end

  // Both stages clear asynchronously
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign syncOut = st_ff.s2;
endmodule

//--- verilog/sbtg_clk_sel.sv
/*
  Clock source selection, external edge synchronisation and prescaler.
  Produces a one-cycle count step. Assumes pin levels arrive already
  passed through a two flip-flop synchroniser.
*/
`timescale 1ns/1ps
module sbtg_clk_sel (
  input  wire logic sys_clk,
  input  wire logic rst,
  sbtg_clk_if.sel   cif
);
  import sbtg_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic [2:0] extPrev;
    logic       pending;
    logic [2:0] psCnt;
  } sbtg_sel_t;

  sbtg_sel_t st_ff;
  sbtg_sel_t nxt_st;

  // Prescale field to last count value: 1, 2, 4 or 8 steps
  function automatic logic [2:0] psLast(input logic [1:0] ps);
    psLast = 3'((4'h1 << ps) - 4'h1);
  endfunction

  logic instrPulse;
  logic [2:0] rise;
  logic rawEdge;
  logic srcEdge;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb begin
    instrPulse = (st_ff.phase == INSTR_DIV_LAST);
    rise = cif.extLevels & ~st_ff.extPrev;
    rawEdge = 1'b0;
    srcEdge = 1'b0;
    nxt_st = st_ff;
    nxt_st.phase = st_ff.phase + 2'h1;
    nxt_st.extPrev = cif.extLevels;
    case (cif.srcSel)
      SRC_INSTR:  srcEdge = instrPulse;
      SRC_SYSTEM: srcEdge = 1'b1;
      SRC_CAP_OSC: rawEdge = rise[2];
      default:    rawEdge = cif.oscEn ? rise[1] : rise[0];
    endcase
    // Synced mode holds an edge until the next instruction boundary
    if (cif.srcSel[1]) begin
      if (cif.syncDis) begin
        srcEdge = rawEdge;
        nxt_st.pending = 1'b0;
      end else begin
        srcEdge = instrPulse & (st_ff.pending | rawEdge);
        nxt_st.pending = (st_ff.pending | rawEdge) & ~instrPulse;
      end
    end else begin
      nxt_st.pending = 1'b0;
    end
    // Prescaler advances only on edges that the gate lets through
    cif.tick = 1'b0;
    if (cif.clear) begin
      nxt_st.psCnt = 3'h0;
    end else if (cif.run && srcEdge) begin
      if (st_ff.psCnt >= psLast(cif.prescale)) begin
        nxt_st.psCnt = 3'h0;
        cif.tick = 1'b1;
      end else begin
        nxt_st.psCnt = st_ff.psCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- verilog/sbtg_top.sv
/*
  Sixteen-bit timer with clock control and gate control registers.
  Holds the two control registers, the gate path (polarity, toggle,
  single pulse), the live gate value and the 16-bit counter.
  Assumes an 8-bit register port clocked by sys_clk, asynchronous
  external pins, and a separate synchronous reset for the reset kinds
  that must leave the control registers alone.
*/
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module sbtg_top (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 otherReset,
  input  wire logic [1:0]           addr,
  input  wire logic [7:0]           wrData,
  input  wire logic                 wrStrobe,
  input  wire logic                 rdStrobe,
  output logic      [7:0]           rdData,
  input  wire logic                 extClockPin,
  input  wire logic                 oscInPin,
  input  wire logic                 capSenseOscillator,
  input  wire logic                 gatePin,
  input  wire logic                 timer0Overflow,
  input  wire logic                 comparatorOneSyncOut,
  input  wire logic                 comparatorTwoSyncOut,
  output logic                      oscDriveEnable,
  output logic      [15:0]          countValue,
  output logic                      gateEventFlag,
  output logic                      rolloverFlag
);
  import sbtg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  clockSourceSelect;
    logic [1:0]  prescaleSelect;
    logic        dedicatedOscEnable;
    logic        extClockSyncDisable;
    logic        timerOn;
    logic        gateEnable;
    logic        gatePolarity;
    logic        gateToggleMode;
    logic        gateSinglePulseMode;
    logic        pulseGoDone;
    logic [1:0]  gateSourceSelect;
    logic        gateValue;
    logic        toggleFlop;
    logic        pulseOpen;
    logic        activePrev;
    logic        stagePrev;
    logic [15:0] count;
    logic        gateEvent;
    logic        rollover;
    logic [7:0]  rdData;
  } sbtg_state_t;

  sbtg_state_t st_ff;
  sbtg_state_t nxt_st;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [6:0] pinsSync;

  // Every outside level passes two flops before any logic here
  sbtg_sync #(
    .W (7)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({comparatorTwoSyncOut, comparatorOneSyncOut,
               timer0Overflow, gatePin, capSenseOscillator,
               oscInPin, extClockPin}),
    .syncOut (pinsSync)
  );

  // ----------------------------------------------------------------
  // Clock selector
  // ----------------------------------------------------------------
  sbtg_clk_if cif ();

  sbtg_clk_sel u_clk_sel (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cif     (cif)
  );

  logic wrClock;
  logic wrGate;
  logic gateRaw;
  logic gateActive;
  logic gateRise;
  logic gateStage;
  logic stageRise;
  logic stageFall;
  logic gateOpen;

  // Register write decode
  always_comb begin
    wrClock = 1'b0;
    wrGate = 1'b0;
    if (wrStrobe && addr == ADDR_CLOCK_CTRL) begin
      wrClock = 1'b1;
    end else if (wrStrobe && addr == ADDR_GATE_CTRL) begin
      wrGate = 1'b1;
    end
  end

  // Gate source multiplexer
  always_comb begin
    case (st_ff.gateSourceSelect)
      GSRC_PIN:    gateRaw = pinsSync[3];
      GSRC_T0_OVF: gateRaw = pinsSync[4];
      GSRC_CMP1:   gateRaw = pinsSync[5];
      default:     gateRaw = pinsSync[6];
    endcase
  end

  // ----------------------------------------------------------------
  // Gate path
  // ----------------------------------------------------------------
  // Polarity folds the gate so that high always means count; the
  // toggle and single-pulse stages then only ever see active levels.
  assign gateActive = st_ff.gatePolarity ? gateRaw : ~gateRaw;
  assign gateRise   = gateActive & ~st_ff.activePrev;
  assign gateStage  = st_ff.gateToggleMode ? st_ff.toggleFlop
                                           : gateActive;
  assign stageRise  = gateStage & ~st_ff.stagePrev;
  assign stageFall  = ~gateStage & st_ff.stagePrev;

  // The gate only matters while the timer runs with gate enable set
  assign gateOpen = ~st_ff.gateEnable | st_ff.gateValue;

  // Clock selector configuration
  assign cif.srcSel    = st_ff.clockSourceSelect;
  assign cif.prescale  = st_ff.prescaleSelect;
  assign cif.oscEn     = st_ff.dedicatedOscEnable;
  assign cif.syncDis   = st_ff.extClockSyncDisable;
  assign cif.run       = st_ff.timerOn & gateOpen;
  assign cif.clear     = wrClock | otherReset;
  assign cif.extLevels = pinsSync[2:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gateEvent = 1'b0;
    nxt_st.rollover = 1'b0;
    nxt_st.activePrev = gateActive;
    nxt_st.stagePrev = gateStage;

    // Toggle flop follows rising active edges in toggle mode
    if (!st_ff.gateToggleMode || !st_ff.timerOn) begin
      nxt_st.toggleFlop = 1'b0;
    end else if (gateRise) begin
      nxt_st.toggleFlop = ~st_ff.toggleFlop;
    end

    // Single pulse opens on a rising stage edge while armed and
    // closes on the trailing edge; nothing reopens until rearmed
    if (!st_ff.gateSinglePulseMode || !st_ff.timerOn) begin
      nxt_st.pulseOpen = 1'b0;
    end else if (st_ff.pulseOpen && stageFall) begin
      nxt_st.pulseOpen = 1'b0;
    end else if (st_ff.pulseGoDone && stageRise) begin
      nxt_st.pulseOpen = 1'b1;
    end

    // Live gate value, shown whether or not the gate is enabled
    if (st_ff.gateSinglePulseMode) begin
      nxt_st.gateValue = nxt_st.pulseOpen;
    end else begin
      nxt_st.gateValue = gateStage;
    end
    if (st_ff.gateValue && !nxt_st.gateValue) begin
      nxt_st.gateEvent = 1'b1;
    end

    // Hardware clears go/done when the captured pulse ends
    if (st_ff.gateSinglePulseMode && st_ff.pulseOpen && stageFall) begin
      nxt_st.pulseGoDone = 1'b0;
    end

    // Count step with wrap; the gate path already held back the tick
    if (otherReset) begin
      nxt_st.count = COUNT_RESET;
    end else if (cif.tick) begin
      nxt_st.count = st_ff.count + 16'h0001;
      if (st_ff.count == COUNT_MAX) begin
        nxt_st.rollover = 1'b1;
      end
    end

    // Software writes; a set of go/done beats a same-cycle clear
    if (wrClock) begin
      nxt_st.clockSourceSelect   = wrData[CC_SRC_LSB +: 2];
      nxt_st.prescaleSelect      = wrData[CC_PS_LSB +: 2];
      nxt_st.dedicatedOscEnable  = wrData[CC_OSC_EN];
      nxt_st.extClockSyncDisable = wrData[CC_SYNC_DIS];
      nxt_st.timerOn             = wrData[CC_TIMER_ON];
    end
    if (wrGate) begin
      nxt_st.gateEnable          = wrData[GC_GATE_EN];
      nxt_st.gatePolarity        = wrData[GC_POLARITY];
      nxt_st.gateToggleMode      = wrData[GC_TOGGLE];
      nxt_st.gateSinglePulseMode = wrData[GC_SPM];
      nxt_st.gateSourceSelect    = wrData[GC_SRC_LSB +: 2];
      if (wrData[GC_GO_DONE]) begin
        nxt_st.pulseGoDone = 1'b1;
      end else begin
        nxt_st.pulseGoDone = 1'b0;
      end
    end

    // Other reset kinds clear counting state only
    if (otherReset) begin
      nxt_st.toggleFlop = 1'b0;
      nxt_st.pulseOpen  = 1'b0;
    end

    // Read data stands for exactly one cycle after the strobe
    nxt_st.rdData = 8'h00;
    if (rdStrobe && addr == ADDR_CLOCK_CTRL) begin
      nxt_st.rdData[CC_SRC_LSB +: 2] = st_ff.clockSourceSelect;
      nxt_st.rdData[CC_PS_LSB +: 2]  = st_ff.prescaleSelect;
      nxt_st.rdData[CC_OSC_EN]       = st_ff.dedicatedOscEnable;
      nxt_st.rdData[CC_SYNC_DIS]     = st_ff.extClockSyncDisable;
      nxt_st.rdData[CC_TIMER_ON]     = st_ff.timerOn;
    end else if (rdStrobe && addr == ADDR_GATE_CTRL) begin
      nxt_st.rdData[GC_GATE_EN]      = st_ff.gateEnable;
      nxt_st.rdData[GC_POLARITY]     = st_ff.gatePolarity;
      nxt_st.rdData[GC_TOGGLE]       = st_ff.gateToggleMode;
      nxt_st.rdData[GC_SPM]          = st_ff.gateSinglePulseMode;
      nxt_st.rdData[GC_GO_DONE]      = st_ff.pulseGoDone;
      nxt_st.rdData[GC_VALUE]        = st_ff.gateValue;
      nxt_st.rdData[GC_SRC_LSB +: 2] = st_ff.gateSourceSelect;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Only the power reset clears the control bits; the other reset
  // kinds arrive on otherReset and are handled above
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdData         = st_ff.rdData;
  assign oscDriveEnable = st_ff.dedicatedOscEnable;
  assign countValue     = st_ff.count;
  assign gateEventFlag  = st_ff.gateEvent;
  assign rolloverFlag   = st_ff.rollover;
endmodule

//--- testbench/sbtg_monitor.sv
/*
  Port-level checker for the timer gate control block.
  Assumes it is bound to the top module with every port by name.
*/
`timescale 1ns/1ps
module sbtg_monitor
  import sbtg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        otherReset,
  input wire logic [1:0]  addr,
  input wire logic [7:0]  wrData,
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic [7:0]  rdData,
  input wire logic        extClockPin,
  input wire logic        oscInPin,
  input wire logic        capSenseOscillator,
  input wire logic        gatePin,
  input wire logic        timer0Overflow,
  input wire logic        comparatorOneSyncOut,
  input wire logic        comparatorTwoSyncOut,
  input wire logic        oscDriveEnable,
  input wire logic [15:0] countValue,
  input wire logic        gateEventFlag,
  input wire logic        rolloverFlag
);
  // --------------------------------------------------------------
  // Shadow copies of software writes
  // --------------------------------------------------------------
  logic [7:0] ccShadow_ff;
  logic [7:0] gcShadow_ff;

  // Other reset kinds leave the shadows alone, as they do the registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ccShadow_ff <= CLOCK_CTRL_RESET;
      gcShadow_ff <= GATE_CTRL_RESET;
    end else if (wrStrobe && addr == ADDR_CLOCK_CTRL) begin
      ccShadow_ff <= wrData;
    end else if (wrStrobe && addr == ADDR_GATE_CTRL) begin
      gcShadow_ff <= wrData;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Go/done and gate value are left out of the gate compare: hardware owns them
  rd_idle_zero_a: assert property (
    !$past(rdStrobe) |-> rdData == 8'h00) else $error("read data not idle");
  clk_ctrl_read_a: assert property (
    rdStrobe && addr == ADDR_CLOCK_CTRL |=> rdData == (ccShadow_ff & 8'hFD))
    else $error("clock control readback wrong");
  gate_ctrl_read_a: assert property (
    rdStrobe && addr == ADDR_GATE_CTRL |=>
      (rdData & 8'hF3) == (gcShadow_ff & 8'hF3))
    else $error("gate control readback wrong");
  void_read_a: assert property (
    rdStrobe && addr[1] |=> rdData == 8'h00) else $error("unmapped read");
  osc_follows_a: assert property (
    wrStrobe && addr == ADDR_CLOCK_CTRL ##1
      !(wrStrobe && addr == ADDR_CLOCK_CTRL) |=>
      oscDriveEnable == $past(wrData[CC_OSC_EN], 2))
    else $error("oscillator enable does not follow");
  count_step_a: assert property (
    $changed(countValue) && !$past(otherReset) |->
      countValue == $past(countValue) + 16'h0001)
    else $error("count jumped");
  count_off_a: assert property (
    !ccShadow_ff[CC_TIMER_ON] [*4] |->
      $stable(countValue) || $past(otherReset))
    else $error("count moved while off");
  roll_flag_a: assert property (
    $past(countValue) == COUNT_MAX && countValue == COUNT_RESET &&
      !$past(otherReset) |-> ##[0:1] rolloverFlag)
    else $error("rollover not flagged");
  roll_pulse_a: assert property (
    rolloverFlag |-> countValue <= 16'h0001 ##1 !rolloverFlag)
    else $error("rollover flag misplaced");
  gate_ev_pulse_a: assert property (
    gateEventFlag |=> !gateEventFlag) else $error("gate event too long");
  // Pin gate held shut past sync and gate latency must freeze the count
  gate_hold_a: assert property (
    (ccShadow_ff[CC_TIMER_ON] && (gcShadow_ff & 8'hB3) == 8'h80 &&
      gatePin != gcShadow_ff[GC_POLARITY]) [*5] |->
      $stable(countValue) || $past(otherReset))
    else $error("count moved with gate shut");
endmodule

//--- testbench/sbtg_far_side.sv
/*
  Far-side model: free-running pin, crystal and sensing oscillators,
  plus gate sources steered by the bench.
  Assumes half periods that never land on a rising system clock edge.
*/
`timescale 1ns/1ps
module sbtg_far_side #(
  parameter int EXT_HALF = 240,
  parameter int OSC_HALF = 320,
  parameter int CAP_HALF = 400
) (
  input  wire logic [3:0] gateDrive,
  output logic            extClockPin,
  output logic            oscInPin,
  output logic            capSenseOscillator,
  output logic            gatePin,
  output logic            timer0Overflow,
  output logic            comparatorOneSyncOut,
  output logic            comparatorTwoSyncOut
);
  // Distinct rates so a wrong source choice shows up as a wrong count
  initial begin
    extClockPin = 1'b0;
    oscInPin = 1'b0;
    capSenseOscillator = 1'b0;
  end
  always #(EXT_HALF) extClockPin = ~extClockPin;
  always #(OSC_HALF) oscInPin = ~oscInPin;
  always #(CAP_HALF) capSenseOscillator = ~capSenseOscillator;

  // Gate sources are plain levels held by the bench
  assign gatePin = gateDrive[0];
  assign timer0Overflow = gateDrive[1];
  assign comparatorOneSyncOut = gateDrive[2];
  assign comparatorTwoSyncOut = gateDrive[3];
endmodule

//--- testbench/sbtg_tb_top.sv
/*
  Bench top: register tasks, rate, gate, single-pulse and rollover runs.
  Assumes the far-side model drives all pins and gates.
*/
`timescale 1ns/1ps
module sbtg_tb_top;
  import sbtg_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        otherReset;
  logic [1:0]  addr;
  logic [7:0]  wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [7:0]  rdData;
  logic [6:0]  pin;
  logic [3:0]  gateDrive;
  logic        oscDriveEnable;
  logic [15:0] countValue;
  logic        gateEventFlag;
  logic        rolloverFlag;
  int          n_mismatch;
  int          checked;
  int          nGateEv;
  int          nRoll;
  int          n0;
  logic [7:0]  rv;
  logic [15:0] dv;
  logic [15:0] c0;
  // System, prescale, instruction, pin sync/unsync, crystal, sensing
  logic [7:0]  ccTab [10] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01,
                              8'h81, 8'h85, 8'h89, 8'hC1, 8'h95};
  int          perTab [10] = '{1, 2, 4, 8, 4, 12, 12, 16, 20, 24};

  sbtg_top u_dut (
    .sys_clk(sys_clk), .rst(rst), .otherReset(otherReset), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .extClockPin(pin[0]), .oscInPin(pin[1]),
    .capSenseOscillator(pin[2]), .gatePin(pin[3]),
    .timer0Overflow(pin[4]), .comparatorOneSyncOut(pin[5]),
    .comparatorTwoSyncOut(pin[6]), .oscDriveEnable(oscDriveEnable),
    .countValue(countValue), .gateEventFlag(gateEventFlag),
    .rolloverFlag(rolloverFlag));

  sbtg_far_side u_far (
    .gateDrive(gateDrive), .extClockPin(pin[0]), .oscInPin(pin[1]),
    .capSenseOscillator(pin[2]), .gatePin(pin[3]),
    .timer0Overflow(pin[4]), .comparatorOneSyncOut(pin[5]),
    .comparatorTwoSyncOut(pin[6]));

  // --------------------------------------------------------------
  // Clock, event counters and tasks
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Flags are one-cycle pulses, so count them rather than poll
  always @(posedge sys_clk) begin
    if (gateEventFlag === 1'b1)
      nGateEv <= nGateEv + 1;
    if (rolloverFlag === 1'b1)
      nRoll <= nRoll + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask

  // Window is a whole number of tick periods, so the delta is exact
  task automatic meas(input int n, output logic [15:0] d);
    logic [15:0] s;
    repeat (10) @(posedge sys_clk);
    #1 s = countValue;
    repeat (n) @(posedge sys_clk);
    #1 d = countValue - s;
  endtask

  task automatic pulse(input int n);
    @(posedge sys_clk);
    gateDrive[0] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    gateDrive[0] <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic soft_reset;
    @(posedge sys_clk);
    otherReset <= 1'b1;
    @(posedge sys_clk);
    otherReset <= 1'b0;
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    otherReset = 1'b0;
    addr = 2'h0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    gateDrive = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_CLOCK_CTRL, rv);
    chk(rv, CLOCK_CTRL_RESET);
    rd(ADDR_GATE_CTRL, rv);
    chk(rv & 8'hFB, GATE_CTRL_RESET);
    wr(ADDR_CLOCK_CTRL, 8'hFF);
    rd(ADDR_CLOCK_CTRL, rv);
    chk(rv, 8'hFD);
    wr(2'h2, 8'hFF);
    rd(2'h2, rv);
    chk(rv, 8'h00);
    wr(ADDR_CLOCK_CTRL, 8'h35);
    soft_reset();
    rd(ADDR_CLOCK_CTRL, rv);
    chk(rv, 8'h35);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_CLOCK_CTRL, ccTab[i]);
      meas(30, dv);
      chk(oscDriveEnable, ccTab[i][CC_OSC_EN]);
      meas(240, dv);
      chk(dv, 16'(240 / perTab[i]));
    end
    wr(ADDR_CLOCK_CTRL, 8'h41);
    for (int g = 0; g < 8; g++) begin
      gateDrive <= {4{~g[0]}};
      wr(ADDR_GATE_CTRL, {1'b1, g[0], 4'h0, g[2:1]});
      meas(40, dv);
      chk(dv, 16'h0000);
      gateDrive[g[2:1]] <= g[0];
      meas(40, dv);
      chk(dv, 16'd40);
      rd(ADDR_GATE_CTRL, rv);
      chk(rv[GC_VALUE], 1'b1);
      n0 = nGateEv;
      gateDrive[g[2:1]] <= ~g[0];
      repeat (10) @(posedge sys_clk);
      chk(16'(nGateEv - n0), 16'h0001);
    end
    gateDrive <= 4'h0;
    wr(ADDR_GATE_CTRL, 8'h40);
    pulse(5);
    meas(40, dv);
    chk(dv, 16'd40);
    wr(ADDR_GATE_CTRL, 8'hC0);
    wr(ADDR_CLOCK_CTRL, 8'h40);
    gateDrive <= 4'h1;
    meas(40, dv);
    chk(dv, 16'h0000);
    gateDrive <= 4'h0;
    wr(ADDR_GATE_CTRL, 8'hE0);
    wr(ADDR_CLOCK_CTRL, 8'h41);
    meas(40, dv);
    chk(dv, 16'h0000);
    pulse(5);
    meas(40, dv);
    chk(dv, 16'd40);
    pulse(5);
    meas(40, dv);
    chk(dv, 16'h0000);
    wr(ADDR_GATE_CTRL, 8'hD8);
    rd(ADDR_GATE_CTRL, rv);
    chk(rv[GC_GO_DONE], 1'b1);
    c0 = countValue;
    pulse(40);
    rd(ADDR_GATE_CTRL, rv);
    chk(rv[GC_GO_DONE], 1'b0);
    dv = countValue - c0;
    chk(dv, 16'd40);
    c0 = countValue;
    pulse(40);
    #1 chk(countValue - c0, 16'h0000);
    wr(ADDR_GATE_CTRL, 8'h00);
    soft_reset();
    n0 = nRoll;
    repeat (65560) @(posedge sys_clk);
    chk(16'(nRoll - n0), 16'h0001);
    test_done();
  end

  // Whole run needs about 70000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
endmodule

bind sbtg_top sbtg_monitor u_mon (
  .sys_clk(sys_clk), .rst(rst), .otherReset(otherReset), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
  .rdData(rdData), .extClockPin(extClockPin), .oscInPin(oscInPin),
  .capSenseOscillator(capSenseOscillator), .gatePin(gatePin),
  .timer0Overflow(timer0Overflow),
  .comparatorOneSyncOut(comparatorOneSyncOut),
  .comparatorTwoSyncOut(comparatorTwoSyncOut),
  .oscDriveEnable(oscDriveEnable), .countValue(countValue),
  .gateEventFlag(gateEventFlag), .rolloverFlag(rolloverFlag));
